/* dv/ulp_channel_bench.sv */
// self-checking bench for the second serial channel
// assumes the line model on the serial side, bench as host
`timescale 1ns/100ps
`default_nettype none
module ulp_channel_bench;
  logic       sys_clk, sys_rst, chip_select_n, read_strobe_n, write_strobe_n;
  logic       rd_data_oe, crystal_output_pin, pump_ready, full_sleep, irq;
  logic       pump_autosleep_pin, bus_isolate_pin, bus_isolated, last;
  logic       second_channel_rx_in, second_channel_tx_out;
  logic       ir_req, pulse_req, inv_req;
  logic [2:0] reg_addr;
  logic [7:0] wr_data, rd_data, dv, sc;
  logic [7:0] ch [8];
  logic [3:0] modem_in, modem_req;
  logic [7:0] exp_q [$];
  int         fail_count, total_checks, seed, n, hi, rises;
  ulp_channel ulp_channel_inst (.sys_clk, .sys_rst, .chip_select_n,
    .reg_addr, .read_strobe_n, .write_strobe_n, .wr_data, .rd_data,
    .rd_data_oe, .pump_autosleep_pin, .bus_isolate_pin, .crystal_output_pin,
    .pump_ready, .full_sleep, .bus_isolated, .irq, .second_channel_rx_in,
    .second_channel_tx_out, .modem_in);
  ulp_line_model ulp_line_model_inst (.sys_clk, .modem_req, .ir_req,
    .pulse_req, .inv_req, .rx_line(second_channel_rx_in),
    .modem_line(modem_in));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("ERROR %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // one strobe cycle, strobe high again for a cycle after
  task automatic bus_cyc(input logic [2:0] a, input logic [7:0] d, input bit w);
    @(negedge sys_clk);
    {reg_addr, wr_data} = {a, d};
    {chip_select_n, read_strobe_n, write_strobe_n} = w ? 3'b010 : 3'b001;
    @(negedge sys_clk);
    {chip_select_n, read_strobe_n, write_strobe_n} = 3'b111;
  endtask : bus_cyc
  task automatic bus_rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus_cyc(a, 8'h00, 1'b0);
  endtask : bus_rd
  // far-side infrared frame: a three-tick pulse for each zero bit
  task automatic ir_send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      pulse_req = !fr[i];
      repeat (3 * dv) @(negedge sys_clk);
      pulse_req = 1'b0;
      repeat (13 * dv) @(negedge sys_clk);
    end
  endtask : ir_send
  always @(posedge sys_clk)
    if (rd_data_oe === 1'b1 && exp_q.size() > 0)
      check(rd_data, exp_q.pop_front());
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    seed = 56;
    {sys_rst, chip_select_n, read_strobe_n, write_strobe_n} = 4'hF;
    {reg_addr, wr_data, modem_req} = 15'h0000;
    {pump_autosleep_pin, bus_isolate_pin, ir_req, pulse_req, inv_req} = 5'h00;
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    bus_cyc(ulp_pkg::OFS_LCTRL, 8'h83, 1'b1);
    bus_rd(ulp_pkg::OFS_DATA, ulp_pkg::REV_CODE);
    bus_rd(ulp_pkg::OFS_IEN, ulp_pkg::ID_CODE);
    dv = 8'(($random(seed) & 8'h03) | 8'h01);
    bus_cyc(ulp_pkg::OFS_DATA, dv, 1'b1);
    bus_rd(ulp_pkg::OFS_DATA, dv);
    bus_rd(ulp_pkg::OFS_ISTAT, ulp_pkg::ISR_NONE);
    bus_cyc(ulp_pkg::OFS_LCTRL, ulp_pkg::LCR_ENH_KEY, 1'b1);
    bus_cyc(ulp_pkg::OFS_ISTAT, 8'h10, 1'b1);
    bus_cyc(ulp_pkg::OFS_IEN, 8'h40, 1'b1);
    for (n = 4; n < 8; n++) ch[n] = 8'($random(seed));
    for (n = 4; n < 8; n++) bus_cyc(n[2:0], ch[n], 1'b1);
    for (n = 4; n < 8; n++) bus_rd(n[2:0], ch[n]);
    bus_rd(ulp_pkg::OFS_IEN, 8'h40);
    bus_cyc(ulp_pkg::OFS_LCTRL, 8'h83, 1'b1);
    bus_cyc(ulp_pkg::OFS_ISTAT, ch[5], 1'b1);
    bus_rd(ulp_pkg::OFS_ISTAT, ch[5]);
    bus_cyc(ulp_pkg::OFS_LCTRL, ulp_pkg::LCR_RST, 1'b1);
    bus_rd(ulp_pkg::OFS_SCR, 8'h00);
    bus_cyc(ulp_pkg::OFS_LCTRL, ulp_pkg::LCR_ENH_KEY, 1'b1);
    bus_cyc(ulp_pkg::OFS_IEN, 8'h00, 1'b1);
    bus_cyc(ulp_pkg::OFS_LCTRL, ulp_pkg::LCR_RST, 1'b1);
    sc = 8'($random(seed));
    bus_cyc(ulp_pkg::OFS_SCR, sc, 1'b1);
    bus_rd(ulp_pkg::OFS_SCR, sc);
    check({7'h00, second_channel_tx_out}, 8'h01);
    bus_cyc(ulp_pkg::OFS_MCTRL, 8'h40, 1'b1);
    ir_req = 1'b1;
    bus_cyc(ulp_pkg::OFS_DATA, 8'h00, 1'b1);
    hi = 0;
    rises = 0;
    last = 1'b0;
    for (n = 0; n < 2000; n++)
    begin
      @(negedge sys_clk);
      hi += second_channel_tx_out;
      rises += (second_channel_tx_out && !last);
      last = second_channel_tx_out;
    end
    check(8'(rises), 8'h09);
    check(8'(hi), 8'(9 * ulp_pkg::PULSE_TICKS * dv));
    check({7'h00, second_channel_tx_out}, 8'h00);
    ch[0] = 8'($random(seed));
    ch[1] = 8'($random(seed));
    ir_send(ch[0]);
    bus_rd(ulp_pkg::OFS_DATA, ch[0]);
    bus_cyc(ulp_pkg::OFS_LCTRL, ulp_pkg::LCR_ENH_KEY, 1'b1);
    bus_cyc(ulp_pkg::OFS_IEN, 8'h04, 1'b1);
    inv_req = 1'b1;
    bus_cyc(ulp_pkg::OFS_LCTRL, ulp_pkg::LCR_RST, 1'b1);
    ir_send(ch[1]);
    bus_rd(ulp_pkg::OFS_DATA, ch[1]);
    bus_cyc(ulp_pkg::OFS_MCTRL, 8'h00, 1'b1);
    ir_req = 1'b0;
    pump_autosleep_pin = 1'b1;
    bus_cyc(ulp_pkg::OFS_IEN, 8'h10, 1'b1);
    for (n = 0; n < 300 && full_sleep !== 1'b1; n++) @(negedge sys_clk);
    check({6'h00, full_sleep, crystal_output_pin}, 8'h02);
    bus_rd(ulp_pkg::OFS_SCR, sc);
    pump_autosleep_pin = 1'b0;
    @(negedge sys_clk);
    check({7'h00, full_sleep}, 8'h00);
    for (n = 0; n < 1300 && pump_ready !== 1'b1; n++) @(negedge sys_clk);
    check({7'h00, pump_ready}, 8'h01);
    bus_isolate_pin = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({7'h00, bus_isolated}, 8'h01);
    bus_cyc(ulp_pkg::OFS_SCR, 8'hFF, 1'b1);
    check({7'h00, bus_isolated}, 8'h01);
    modem_req = 4'h1;
    for (n = 0; n < 100 && irq !== 1'b1; n++) @(negedge sys_clk);
    check({6'h00, bus_isolated, irq}, 8'h01);
    bus_rd(ulp_pkg::OFS_ISTAT, ulp_pkg::ISR_NONE);
    check({7'h00, irq}, 8'h00);
    bus_rd(ulp_pkg::OFS_MSTAT, 8'h11);
    for (n = 0; n < 300 && bus_isolated !== 1'b1; n++) @(negedge sys_clk);
    check({7'h00, bus_isolated}, 8'h01);
    bus_isolate_pin = 1'b0;
    @(negedge sys_clk);
    check({7'h00, bus_isolated}, 8'h00);
    bus_rd(ulp_pkg::OFS_SCR, sc);
    repeat (4) @(negedge sys_clk);
    give_verdict();
  end
endmodule : ulp_channel_bench
`default_nettype wire

/* dv/ulp_checker.sv */
// port checker for the second serial channel
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module ulp_checker
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // watched pins
  input wire logic       chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic       rd_data_oe,
  input wire logic       pump_autosleep_pin,
  input wire logic       bus_isolate_pin,
  input wire logic       crystal_output_pin,
  input wire logic       pump_ready,
  input wire logic       full_sleep,
  input wire logic       bus_isolated,
  input wire logic       second_channel_rx_in,
  input wire logic [3:0] modem_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // cycles since full sleep ended while the pump is not yet ready
  logic [11:0] wait_reg;
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      wait_reg <= 12'h000;
    else if (full_sleep || pump_ready)
      wait_reg <= 12'h000;
    else
      wait_reg <= wait_reg + 12'h001;
  // a steady receive line is idle in either mode, since sleep needs idle
  sequence quiet_iso;
    bus_isolated && $stable(second_channel_rx_in) && $stable(modem_in);
  endsequence
  sequence no_wake;
    bus_isolate_pin && $stable(second_channel_rx_in) && $stable(modem_in);
  endsequence
  chk_bus_no_wake: assert property (
    quiet_iso ##1 no_wake [*4] |-> bus_isolated) else $error("woke idle");
  chk_full_pin: assert property (
    full_sleep |-> pump_autosleep_pin && !crystal_output_pin)
    else $error("full sleep without pin or with clock");
  chk_isolate_pin: assert property (
    !bus_isolate_pin |-> !bus_isolated) else $error("isolated, pin low");
  chk_read_drive: assert property (
    !chip_select_n && !read_strobe_n && !bus_isolated |-> rd_data_oe)
    else $error("read not driven");
  chk_no_drive: assert property (
    rd_data_oe |-> !chip_select_n && !read_strobe_n && !bus_isolated)
    else $error("bus driven without read");
  chk_pump_low: assert property (
    $fell(full_sleep) |=> !pump_ready [*8]) else $error("pump early");
  chk_pump_early: assert property (
    $rose(pump_ready) |-> wait_reg >= 12'h460) else $error("pump early");
  chk_pump_late: assert property (
    wait_reg <= 12'h46A) else $error("pump late");
endmodule : ulp_checker
bind ulp_channel ulp_checker ulp_checker_inst (.sys_clk, .sys_rst,
  .chip_select_n, .read_strobe_n, .rd_data_oe, .pump_autosleep_pin,
  .bus_isolate_pin, .crystal_output_pin, .pump_ready, .full_sleep,
  .bus_isolated, .second_channel_rx_in, .modem_in);
`default_nettype wire

/* dv/ulp_line_model.sv */
// remote line side: receive line and modem inputs
// assumes the bench requests modem levels, infrared mode, pulses, polarity
`timescale 1ns/100ps
`default_nettype none
module ulp_line_model
(
  // clock and request
  input  wire logic       sys_clk,
  input  wire logic [3:0] modem_req,
  input  wire logic       ir_req,
  input  wire logic       pulse_req,
  input  wire logic       inv_req,
  // line pins
  output logic            rx_line,
  output logic [3:0]      modem_line
);
  // infrared idles low, optional inversion
  // plain serial idles high so the receiver and wake logic stay quiet
  assign rx_line = ir_req ? (pulse_req ^ inv_req) : 1'b1;
  always @(negedge sys_clk)
    modem_line <= modem_req;
endmodule : ulp_line_model
`default_nettype wire

/* rtl/ulp_channel.sv */
// second serial channel: register select, sleep, power-save, infrared
// assumes strobes are synchronous to sys_clk; serializer is simplified
`timescale 1ns/100ps
`default_nettype none
module ulp_channel
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // register bus
  input  wire logic       chip_select_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            rd_data_oe,
  // power pins
  input  wire logic       pump_autosleep_pin,
  input  wire logic       bus_isolate_pin,
  output logic            crystal_output_pin,
  output logic            pump_ready,
  output logic            full_sleep,
  output logic            bus_isolated,
  output logic            irq,
  // serial pins
  input  wire logic       second_channel_rx_in,
  output logic            second_channel_tx_out,
  input  wire logic [3:0] modem_in
);
  logic [7:0] line_control_reg, interrupt_enables_reg, modem_control_reg;
  logic [7:0] feature_control_reg, enhanced_function_reg, scratch_reg;
  logic [7:0] baud_divisor_low_reg, baud_divisor_high_reg;
  logic [7:0] baud_divisor_fraction_reg, fifo_trigger_level_reg;
  logic [7:0] enhanced_mode_select_reg, queue_control_reg;
  logic [7:0] resume_char_reg [0:1];
  logic [7:0] pause_char_reg  [0:1];
  logic [7:0] receive_holding_reg, transmit_holding_reg;
  logic       rx_ready_reg, tx_busy_reg, wake_irq_reg;
  logic [3:0] modem_delta_reg, modem_prev_reg;
  logic       asleep_reg, osc_ok_reg, rd_prev_reg, wr_prev_reg;
  logic [7:0] osc_cnt_reg;
  logic [10:0] pump_cnt_reg;
  logic [3:0] tick_cnt_reg, tx_phase_reg, tx_bits_reg, rx_phase_reg;
  logic [9:0] tx_shift_reg;
  logic [3:0] rx_bits_reg;
  logic [7:0] rx_shift_reg;
  logic       rx_busy_reg;
  logic [3:0] pulse_len_reg;
  logic       ir_prev_reg, ir_seen_reg;

  logic enh_bank, div_bank, div_zero, ir_on, rd_pulse, wr_pulse;
  logic rx_line, rx_nrz, tick, int_pending, sleep_ok, wake_event;
  logic [7:0] isr_val;

  // ************************************************************
  // register select
  // ************************************************************
  function automatic logic is_addr(input logic [2:0] a, input logic [2:0] b);
    is_addr = (a == b);
  endfunction : is_addr

  assign enh_bank = (line_control_reg == ulp_pkg::LCR_ENH_KEY);
  assign div_bank = line_control_reg[ulp_pkg::LCR_DIV_BIT] && !enh_bank;
  assign div_zero = (baud_divisor_low_reg == ulp_pkg::RST_ZERO) &&
                    (baud_divisor_high_reg == ulp_pkg::RST_ZERO);
  assign ir_on    = modem_control_reg[ulp_pkg::MCR_IR_BIT];

  assign bus_isolated = bus_isolate_pin && asleep_reg;

  assign rd_pulse = !chip_select_n && !read_strobe_n && rd_prev_reg &&
                    !bus_isolated;
  assign wr_pulse = !chip_select_n && !write_strobe_n && wr_prev_reg &&
                    !bus_isolated;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
    end
    else
    begin
      rd_prev_reg <= read_strobe_n || chip_select_n;
      wr_prev_reg <= write_strobe_n || chip_select_n;
    end

  // ************************************************************
  // interrupt status
  // ************************************************************
  assign int_pending = (interrupt_enables_reg[0] && rx_ready_reg) ||
                       (interrupt_enables_reg[1] && !tx_busy_reg) ||
                       (interrupt_enables_reg[3] && (modem_delta_reg != 4'h0));

  always_comb
  begin
    if (interrupt_enables_reg[0] && rx_ready_reg)
      isr_val = ulp_pkg::ISR_RXRDY;
    else if (interrupt_enables_reg[1] && !tx_busy_reg)
      isr_val = ulp_pkg::ISR_THRE;
    else if (interrupt_enables_reg[3] && (modem_delta_reg != 4'h0))
      isr_val = ulp_pkg::ISR_MODEM;
    else
      isr_val = ulp_pkg::ISR_NONE;
  end

  assign irq = int_pending || (wake_irq_reg && !int_pending &&
               (interrupt_enables_reg[3:0] == 4'h0));

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb
  begin
    rd_data = ulp_pkg::RST_ZERO;
    unique case (reg_addr)
      ulp_pkg::OFS_DATA:
        if (enh_bank) rd_data = {4'h0, rx_ready_reg, 3'h0};
        // revision in place of zero divisor
        else if (div_bank) rd_data = div_zero ? ulp_pkg::REV_CODE
                                              : baud_divisor_low_reg;
        else rd_data = receive_holding_reg;
      ulp_pkg::OFS_IEN:
        if (enh_bank) rd_data = feature_control_reg;
        else if (div_bank) rd_data = div_zero ? ulp_pkg::ID_CODE
                                              : baud_divisor_high_reg;
        else rd_data = interrupt_enables_reg;
      ulp_pkg::OFS_ISTAT:
        if (enh_bank) rd_data = enhanced_function_reg;
        else if (div_bank && enhanced_function_reg[ulp_pkg::EFR_ENH_BIT])
          rd_data = baud_divisor_fraction_reg;
        else rd_data = isr_val;
      ulp_pkg::OFS_LCTRL: rd_data = line_control_reg;
      ulp_pkg::OFS_MCTRL:
        rd_data = enh_bank ? resume_char_reg[0] : modem_control_reg;
      ulp_pkg::OFS_LSTAT:
        rd_data = enh_bank ? resume_char_reg[1]
                : {1'b0, !tx_busy_reg, !tx_busy_reg, 4'h0, rx_ready_reg};
      ulp_pkg::OFS_MSTAT:
        rd_data = enh_bank ? pause_char_reg[0]
                : {modem_in, modem_delta_reg};
      ulp_pkg::OFS_SCR:
        if (enh_bank) rd_data = pause_char_reg[1];
        else if (feature_control_reg[ulp_pkg::FEATURE_CONTROL_SEL_BIT])
          rd_data = {7'h00, rx_ready_reg};
        else rd_data = scratch_reg;
    endcase
  end

  assign rd_data_oe = !chip_select_n && !read_strobe_n && !bus_isolated;

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      line_control_reg          <= ulp_pkg::LCR_RST;
      interrupt_enables_reg     <= ulp_pkg::RST_ZERO;
      modem_control_reg         <= ulp_pkg::RST_ZERO;
      feature_control_reg       <= ulp_pkg::RST_ZERO;
      enhanced_function_reg     <= ulp_pkg::RST_ZERO;
      scratch_reg               <= ulp_pkg::RST_ZERO;
      baud_divisor_low_reg      <= ulp_pkg::RST_ZERO;
      baud_divisor_high_reg     <= ulp_pkg::RST_ZERO;
      baud_divisor_fraction_reg <= ulp_pkg::RST_ZERO;
      fifo_trigger_level_reg    <= ulp_pkg::RST_ZERO;
      enhanced_mode_select_reg  <= ulp_pkg::RST_ZERO;
      queue_control_reg         <= ulp_pkg::RST_ZERO;
      resume_char_reg[0]        <= ulp_pkg::RST_ZERO;
      resume_char_reg[1]        <= ulp_pkg::RST_ZERO;
      pause_char_reg[0]         <= ulp_pkg::RST_ZERO;
      pause_char_reg[1]         <= ulp_pkg::RST_ZERO;
    end
    else if (wr_pulse)
    begin
      if (enh_bank)
        unique case (reg_addr)
          ulp_pkg::OFS_DATA:  fifo_trigger_level_reg <= wr_data;
          ulp_pkg::OFS_IEN:   feature_control_reg    <= wr_data;
          ulp_pkg::OFS_ISTAT: enhanced_function_reg  <= wr_data;
          ulp_pkg::OFS_LCTRL: line_control_reg       <= wr_data;
          ulp_pkg::OFS_MCTRL: resume_char_reg[0]     <= wr_data;
          ulp_pkg::OFS_LSTAT: resume_char_reg[1]     <= wr_data;
          ulp_pkg::OFS_MSTAT: pause_char_reg[0]      <= wr_data;
          ulp_pkg::OFS_SCR:   pause_char_reg[1]      <= wr_data;
        endcase
      else
        unique case (reg_addr)
          ulp_pkg::OFS_DATA:
            if (div_bank) baud_divisor_low_reg <= wr_data;
          ulp_pkg::OFS_IEN:
            if (div_bank) baud_divisor_high_reg <= wr_data;
            else interrupt_enables_reg <= wr_data;
          ulp_pkg::OFS_ISTAT:
            if (div_bank && enhanced_function_reg[ulp_pkg::EFR_ENH_BIT])
              baud_divisor_fraction_reg <= wr_data;
            else queue_control_reg <= wr_data;
          ulp_pkg::OFS_LCTRL: line_control_reg  <= wr_data;
          ulp_pkg::OFS_MCTRL: modem_control_reg <= wr_data;
          ulp_pkg::OFS_LSTAT, ulp_pkg::OFS_MSTAT: ;
          ulp_pkg::OFS_SCR:
            if (feature_control_reg[ulp_pkg::FEATURE_CONTROL_SEL_BIT])
              enhanced_mode_select_reg <= wr_data;
            else scratch_reg <= wr_data;
        endcase
    end

  // ************************************************************
  // sleep, full sleep and wake
  // ************************************************************
  // infrared idle low, optional inversion
  assign rx_line = ir_on ? (second_channel_rx_in ^
                   feature_control_reg[ulp_pkg::FEATURE_CONTROL_INV_BIT])
                 : second_channel_rx_in;
  // wake on start bit, modem change, a write when not isolated, or sleep bit clear
  assign wake_event = (ir_on ? rx_line : !rx_line) ||
                      (modem_in != modem_prev_reg);
  assign sleep_ok = interrupt_enables_reg[ulp_pkg::IER_SLEEP_BIT] &&
                    !int_pending && !wake_irq_reg && !div_zero &&
                    (modem_delta_reg == 4'h0) && rx_nrz && !rx_busy_reg &&
                    !tx_busy_reg;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      asleep_reg   <= 1'b0;
      osc_ok_reg   <= 1'b1;
      osc_cnt_reg  <= 8'h00;
      wake_irq_reg <= 1'b0;
    end
    else
    begin
      if (!asleep_reg && osc_ok_reg && sleep_ok)
        asleep_reg <= 1'b1;
      else if (asleep_reg && (wake_event ||
               !interrupt_enables_reg[ulp_pkg::IER_SLEEP_BIT] ||
               (wr_pulse && !bus_isolate_pin)))
      begin
        asleep_reg  <= 1'b0;
        osc_ok_reg  <= 1'b0;
        osc_cnt_reg <= 8'h00;
      end
      else if (!osc_ok_reg)
      begin
        osc_cnt_reg <= osc_cnt_reg + 8'h01;
        if (osc_cnt_reg == 8'(ulp_pkg::OSC_START_CYC - 1))
          osc_ok_reg <= 1'b1;
      end
      // raise wake once oscillator is ready
      if (!osc_ok_reg && osc_cnt_reg == 8'(ulp_pkg::OSC_START_CYC - 1) &&
          interrupt_enables_reg[ulp_pkg::IER_SLEEP_BIT])
        wake_irq_reg <= 1'b1;
      else if (rd_pulse && !enh_bank && is_addr(reg_addr, ulp_pkg::OFS_ISTAT))
        wake_irq_reg <= 1'b0;
    end

  assign crystal_output_pin = osc_ok_reg && !asleep_reg && tick_cnt_reg[0];
  // full sleep, exit on pin or on leaving sleep
  assign full_sleep = asleep_reg && pump_autosleep_pin;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      pump_cnt_reg <= 11'(ulp_pkg::PUMP_WAKE_CYC);
    else if (full_sleep)
      pump_cnt_reg <= 11'h000;
    else if (pump_cnt_reg != 11'(ulp_pkg::PUMP_WAKE_CYC))
      pump_cnt_reg <= pump_cnt_reg + 11'h001;

  assign pump_ready = (pump_cnt_reg == 11'(ulp_pkg::PUMP_WAKE_CYC));

  // ************************************************************
  // modem deltas
  // ************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      modem_prev_reg  <= 4'h0;
      modem_delta_reg <= 4'h0;
    end
    else
    begin
      modem_prev_reg <= modem_in;
      // a new change wins over the clearing read
      if (rd_pulse && !enh_bank && is_addr(reg_addr, ulp_pkg::OFS_MSTAT))
        modem_delta_reg <= modem_in ^ modem_prev_reg;
      else
        modem_delta_reg <= modem_delta_reg | (modem_in ^ modem_prev_reg);
    end

  // ************************************************************
  // sixteen-times tick from divisor (integer part only)
  // ************************************************************
  logic [15:0] div_cnt_reg;
  assign tick = (div_cnt_reg == 16'h0000) && !div_zero && !asleep_reg;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      div_cnt_reg  <= 16'h0000;
      tick_cnt_reg <= 4'h0;
    end
    else if (div_zero || asleep_reg)
      div_cnt_reg <= 16'h0000;
    else if (tick)
    begin
      div_cnt_reg  <= {baud_divisor_high_reg, baud_divisor_low_reg} - 16'h0001;
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
    end
    else
      div_cnt_reg <= div_cnt_reg - 16'h0001;

  // ************************************************************
  // transmitter with infrared encoder
  // ************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= 10'h3FF;
      tx_phase_reg <= 4'h0;
      tx_bits_reg  <= 4'h0;
      transmit_holding_reg <= 8'h00;
    end
    else if (wr_pulse && !enh_bank && !div_bank &&
             is_addr(reg_addr, ulp_pkg::OFS_DATA) && !tx_busy_reg)
    begin
      transmit_holding_reg <= wr_data;
      tx_shift_reg <= {1'b1, wr_data, 1'b0};
      tx_busy_reg  <= 1'b1;
      tx_phase_reg <= 4'h0;
      tx_bits_reg  <= 4'h0;
    end
    else if (tx_busy_reg && tick)
    begin
      tx_phase_reg <= tx_phase_reg + 4'h1;
      if (tx_phase_reg == 4'(ulp_pkg::BIT_TICKS - 1))
      begin
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bits_reg  <= tx_bits_reg + 4'h1;
        if (tx_bits_reg == 4'h9)
          tx_busy_reg <= 1'b0;
      end
    end

  // pulse on zero bits, idle low
  // encoder exists on this channel only
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      second_channel_tx_out <= 1'b1;
    else if (ir_on)
      second_channel_tx_out <= tx_busy_reg && !tx_shift_reg[0] &&
                               (tx_phase_reg < 4'(ulp_pkg::PULSE_TICKS));
    else
      second_channel_tx_out <= tx_shift_reg[0];

  // ************************************************************
  // receiver with infrared decoder
  // ************************************************************
  // pulse seen within a bit makes a zero
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ir_prev_reg   <= 1'b0;
      ir_seen_reg   <= 1'b0;
      pulse_len_reg <= 4'h0;
    end
    else
    begin
      ir_prev_reg <= rx_line;
      if (tick && rx_line)
        pulse_len_reg <= (pulse_len_reg == 4'hF) ? pulse_len_reg
                                                 : pulse_len_reg + 4'h1;
      else if (!rx_line)
        pulse_len_reg <= 4'h0;
      if (rx_line && !ir_prev_reg)
        ir_seen_reg <= 1'b1;
      else if (tick && rx_phase_reg == 4'hF && !rx_line)
        ir_seen_reg <= 1'b0;
    end

  assign rx_nrz = ir_on ? !(ir_seen_reg || rx_line) : rx_line;

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      rx_busy_reg  <= 1'b0;
      rx_phase_reg <= 4'h0;
      rx_bits_reg  <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_ready_reg <= 1'b0;
      receive_holding_reg <= 8'h00;
    end
    else
    begin
      if (!rx_busy_reg && !rx_nrz && tick)
      begin
        rx_busy_reg  <= 1'b1;
        rx_phase_reg <= 4'h0;
        rx_bits_reg  <= 4'h0;
      end
      else if (rx_busy_reg && tick)
      begin
        rx_phase_reg <= rx_phase_reg + 4'h1;
        if (rx_phase_reg == 4'h7)
        begin
          rx_bits_reg <= rx_bits_reg + 4'h1;
          if (rx_bits_reg != 4'h0 && rx_bits_reg != 4'h9)
            rx_shift_reg <= {rx_nrz, rx_shift_reg[7:1]};
          if (rx_bits_reg == 4'h9)
            rx_busy_reg <= 1'b0;
        end
      end
      // new byte wins over the clearing read
      if (rx_busy_reg && tick && rx_phase_reg == 4'h7 && rx_bits_reg == 4'h9)
      begin
        receive_holding_reg <= rx_shift_reg;
        rx_ready_reg <= 1'b1;
      end
      else if (rd_pulse && !enh_bank && !div_bank &&
               is_addr(reg_addr, ulp_pkg::OFS_DATA))
        rx_ready_reg <= 1'b0;
    end
endmodule : ulp_channel
`default_nettype wire

/* rtl/ulp_pkg.sv */
// constants for the low-power infrared serial channel with register select
// assumes a 25 MHz system clock and a parallel register bus
package ulp_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [2:0] OFS_DATA   = 3'h0;
  localparam logic [2:0] OFS_IEN    = 3'h1;
  localparam logic [2:0] OFS_ISTAT  = 3'h2;
  localparam logic [2:0] OFS_LCTRL  = 3'h3;
  localparam logic [2:0] OFS_MCTRL  = 3'h4;
  localparam logic [2:0] OFS_LSTAT  = 3'h5;
  localparam logic [2:0] OFS_MSTAT  = 3'h6;
  localparam logic [2:0] OFS_SCR    = 3'h7;
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int LCR_DIV_BIT   = 7;
  localparam int IER_SLEEP_BIT = 4;
  localparam int MCR_IR_BIT    = 6;
  localparam int FEATURE_CONTROL_INV_BIT  = 2;
  localparam int FEATURE_CONTROL_SEL_BIT  = 6;
  localparam int EFR_ENH_BIT   = 4;
  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] LCR_RST    = 8'h03;
  localparam logic [7:0] ISR_NONE   = 8'h01;
  localparam logic [7:0] ISR_THRE   = 8'h02;
  localparam logic [7:0] ISR_RXRDY  = 8'h04;
  localparam logic [7:0] ISR_MODEM  = 8'h00;
  // identification values are arbitrary
  localparam logic [7:0] REV_CODE   = 8'h5A;
  localparam logic [7:0] ID_CODE    = 8'hA5;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ        = 25000000;
  localparam int PUMP_WAKE_US  = 45;
  localparam int PUMP_WAKE_CYC = (PUMP_WAKE_US * (CLK_HZ / 1000000));
  localparam int OSC_START_CYC = 16;
  localparam int PULSE_TICKS   = 3;
  localparam int BIT_TICKS     = 16;
  localparam int MIN_PULSE     = 2;
endpackage : ulp_pkg
